// ---- cvsd_cfg.svh ----
`ifndef CVSD_CFG_SVH
`define CVSD_CFG_SVH

// Reference clock and the slowest supported bit clock
`define CVSD_REF_HZ      25000000
`define CVSD_MIN_BIT_HZ  9600
// Longest bit period in reference cycles, rounded down
`define CVSD_LOSS_CYC    (`CVSD_REF_HZ / `CVSD_MIN_BIT_HZ)

// Reset values and limits
`define CVSD_HIST_RST    3'h2
`define CVSD_LVL_MIN     12'h010
`define CVSD_LVL_MAX     12'hfff
`define CVSD_INTEG_RST   16'sh0000
`define CVSD_INTEG_POS   18'sh07fff
`define CVSD_INTEG_NEG   18'sh38001

// Filter shifts: syllabic time constant and integrator leak
`define CVSD_SYL_SHIFT   4
`define CVSD_LEAK_SHIFT  6

// Sample buffer depth
`define CVSD_FIFO_DEPTH  16

`endif

// ---- cvsd_pkg.sv ----
package cvsd_pkg;

  typedef enum logic
  {
    CVSD_LOST = 1'b0,
    CVSD_RUN  = 1'b1
  } cvsd_link_t;

  typedef struct packed
  {
    logic               chan_bit;
    logic signed [15:0] integ;
  } cvsd_smp_t;

endpackage

// ---- cvsd_fifo.sv ----
`timescale 1ns/1ps

module cvsd_fifo
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic [AW:0]      fill;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             push;
  logic             pop;

  assign fill      = wr_q - rd_q;
  assign in_ready  = fill != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

  // Storage needs no reset; only the pointers define what is valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule

// ---- cvsd_core.sv ----
`timescale 1ns/1ps
`include "cvsd_cfg.svh"

// Functional notes
// RULE_01: Encode bit is sign of input minus integrator
// RULE_02: Sign bit is output and steers ramp
// RULE_03: Sample comparison once per bit clock
// RULE_04: Three-bit history shifts each bit period
// RULE_05: Coincidence when history all ones or zeros
// RULE_06: Coincidence charges syllabic level setting step size
// RULE_07: Step magnitude from level, polarity from bit
// RULE_08: No input gives alternating one-zero stream
// RULE_09: Decoder reuses identical coincidence and syllabic logic
// RULE_10: Received bits drive identical integrator
// RULE_11: Past bits only, one bit per clock
// RULE_12: Unframed; leaky integrator decays on data loss
// RULE_13: Bit clock between 9.6 and 64 kHz
// RULE_14: History and output update on falling edge
// RULE_15: Mode high selects comparator, low data input
// RULE_16: Coincidence output is active low
// RULE_17: Data input inverted relative to output bit
// RULE_18: Reset loads alternating history, minimum level
module cvsd_core
  import cvsd_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               bit_clk,
  input  wire logic               enc_mode,
  input  wire logic               data_in,
  input  wire logic signed [15:0] analog_in,
  output logic                    ser_out,
  output logic                    coinc_n,
  output logic signed      [15:0] integ_out,
  output logic                    link_lost,
  output logic                    smp_valid,
  input  wire logic               smp_ready,
  output cvsd_smp_t               smp_data,
  output logic                    smp_space
);

  function automatic logic all_same(input logic [2:0] h);
    all_same = (h == 3'h7) || (h == 3'h0);
  endfunction

  // Syllabic move toward a bound; never stalls short of it
  function automatic logic [11:0] syl_step(input logic [11:0] gap);
    logic [11:0] s;
    s = gap >> `CVSD_SYL_SHIFT;
    syl_step = (s == 12'h000) ? {11'h000, |gap} : s;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    logic signed [17:0] lim;
    lim = v;
    if (v > `CVSD_INTEG_POS)
      lim = `CVSD_INTEG_POS;
    else if (v < `CVSD_INTEG_NEG)
      lim = `CVSD_INTEG_NEG;
    sat16 = lim[15:0];
  endfunction

  // Pin synchronisers; the analog word is assumed to move slowly
  logic                bclk_s1_q;
  logic                bclk_s2_q;
  logic                bclk_d_q;
  logic                enc_s1_q;
  logic                enc_s_q;
  logic                dat_s1_q;
  logic                dat_s_q;
  logic signed  [15:0] ana_s1_q;
  logic signed  [15:0] ana_s_q;
  logic signed  [15:0] ana_s3_q;
  logic signed  [15:0] ana_h_q;
  logic signed  [15:0] ana_h_d;
  logic                ana_same;

  logic         [2:0]  hist_q;
  logic         [2:0]  hist_d;
  logic         [11:0] lvl_q;
  logic         [11:0] lvl_d;
  logic signed  [15:0] integ_q;
  logic signed  [15:0] integ_d;
  logic                ser_q;
  logic                coinc_n_q;
  logic         [11:0] cnt_q;
  logic         [11:0] cnt_d;
  cvsd_link_t          link_q;
  cvsd_link_t          link_d;

  logic                fall;
  logic                tick;
  logic                sign_bit;
  logic                rx_bit;
  logic                bit_nxt;
  logic                coinc_now;
  logic         [11:0] lvl_up;
  logic         [11:0] lvl_dn;
  logic signed  [17:0] integ_x;
  logic signed  [17:0] leaked;
  logic signed  [17:0] step_x;
  logic signed  [17:0] ramped;
  cvsd_smp_t           push_smp;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_d_q  <= 1'b0;
      enc_s1_q  <= 1'b0;
      enc_s_q   <= 1'b0;
      dat_s1_q  <= 1'b0;
      dat_s_q   <= 1'b0;
      ana_s1_q  <= 16'sh0000;
      ana_s_q   <= 16'sh0000;
      ana_s3_q  <= 16'sh0000;
      ana_h_q   <= 16'sh0000;
    end
    else
    begin
      bclk_s1_q <= bit_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_d_q  <= bclk_s2_q;
      enc_s1_q  <= enc_mode;
      enc_s_q   <= enc_s1_q;
      dat_s1_q  <= data_in;
      dat_s_q   <= dat_s1_q;
      ana_s1_q  <= analog_in;
      ana_s_q   <= ana_s1_q;
      ana_s3_q  <= ana_s_q;
      ana_h_q   <= ana_h_d;
    end
  end

  // One update per falling edge of the bit clock
  assign fall      = bclk_d_q & ~bclk_s2_q; // RULE_14 RULE_03

  // A stopped bit clock must still let the integrator leak away
  assign tick      = ~fall && (cnt_q == 12'(`CVSD_LOSS_CYC - 1)); // RULE_12
  assign cnt_d     = (fall || tick) ? 12'h000 : cnt_q + 12'h001;
  assign link_d    = fall ? CVSD_RUN : (tick ? CVSD_LOST : link_q);

  // The input word crosses as a bus; only a value seen twice is used,
  // so a sample taken mid-change never reaches the comparator
  assign ana_same  = ana_s_q == ana_s3_q;
  assign ana_h_d   = ana_same ? ana_s_q : ana_h_q;
  assign sign_bit  = ana_h_q > integ_q; // RULE_01
  assign rx_bit    = ~dat_s_q; // RULE_17
  assign bit_nxt   = enc_s_q ? sign_bit : rx_bit; // RULE_15 RULE_10

  // History and level see only bits already sent
  assign hist_d    = fall ? {hist_q[1:0], bit_nxt} : hist_q; // RULE_04 RULE_11
  assign coinc_now = all_same(hist_q); // RULE_05 RULE_09

  assign lvl_up    = lvl_q + syl_step(`CVSD_LVL_MAX - lvl_q);
  assign lvl_dn    = lvl_q - syl_step(lvl_q - `CVSD_LVL_MIN);
  assign lvl_d     = fall ? (coinc_now ? lvl_up : lvl_dn) : // RULE_06
                     (tick ? lvl_dn : lvl_q);

  assign integ_x   = {{2{integ_q[15]}}, integ_q};
  assign leaked    = integ_x - (integ_x >>> `CVSD_LEAK_SHIFT); // RULE_12
  assign step_x    = {6'h00, lvl_q};
  assign ramped    = bit_nxt ? leaked + step_x : leaked - step_x; // RULE_07
  // The minimum step keeps an idle loop toggling around the input
  assign integ_d   = fall ? sat16(ramped) : // RULE_02 RULE_08
                     (tick ? sat16(leaked) : integ_q);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_q    <= `CVSD_HIST_RST; // RULE_18
      lvl_q     <= `CVSD_LVL_MIN; // RULE_18
      integ_q   <= `CVSD_INTEG_RST;
      ser_q     <= 1'b0;
      coinc_n_q <= 1'b1;
      cnt_q     <= 12'h000;
      link_q    <= CVSD_LOST;
    end
    else
    begin
      hist_q    <= hist_d;
      lvl_q     <= lvl_d;
      integ_q   <= integ_d;
      ser_q     <= fall ? bit_nxt : ser_q; // RULE_02
      coinc_n_q <= ~all_same(hist_d); // RULE_16
      cnt_q     <= cnt_d;
      link_q    <= link_d;
    end
  end

  assign ser_out   = ser_q;
  assign coinc_n   = coinc_n_q;
  assign integ_out = integ_q;
  assign link_lost = (link_q == CVSD_LOST);

  // One buffered sample per channel bit; overflow drops new samples
  assign push_smp.chan_bit = bit_nxt;
  assign push_smp.integ    = integ_d;

  cvsd_fifo
  #(
    .WIDTH ($bits(cvsd_smp_t)),
    .DEPTH (`CVSD_FIFO_DEPTH)
  )
  u_fifo
  (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (fall),
    .in_ready  (smp_space),
    .in_data   (push_smp),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_hist_shift: assert property ( // RULE_04
    fall |=> hist_q == {$past(hist_q[1:0]), $past(bit_nxt)})
    else $error("history did not shift in new bit");

  a_hist_hold: assert property ( // RULE_14
    !fall |=> $stable(hist_q) && $stable(ser_q))
    else $error("history or output moved without falling edge");

  a_enc_sign: assert property ( // RULE_01
    fall && enc_s_q |=> ser_out == $past(ana_h_q > integ_q))
    else $error("encode bit is not comparator sign");

  a_dec_invert: assert property ( // RULE_17
    fall && !enc_s_q |=> ser_out == !$past(dat_s_q))
    else $error("decode bit is not inverted data input");

  a_coinc_low: assert property ( // RULE_16
    coinc_n == !((hist_q == 3'h7) || (hist_q == 3'h0)))
    else $error("coincidence output disagrees with history");

  a_lvl_charge: assert property ( // RULE_06
    fall && coinc_now && lvl_q < `CVSD_LVL_MAX |=> lvl_q > $past(lvl_q))
    else $error("level did not rise on coincidence");

  a_lvl_decay: assert property ( // RULE_06
    fall && !coinc_now && lvl_q > `CVSD_LVL_MIN |=> lvl_q < $past(lvl_q))
    else $error("level did not decay without coincidence");

  a_ramp_up: assert property ( // RULE_07
    fall && bit_nxt && integ_q <= 0 |=> integ_q > $past(integ_q))
    else $error("integrator did not ramp up on one");

  a_ramp_down: assert property ( // RULE_07
    fall && !bit_nxt && integ_q >= 0 |=> integ_q < $past(integ_q))
    else $error("integrator did not ramp down on zero");

  a_loss_flag: assert property ( // RULE_12
    tick |=> link_lost ##1 (link_lost || $past(fall)))
    else $error("link loss not flagged after timeout");

  a_loss_decay: assert property ( // RULE_12
    tick && integ_q > 16'sh0040 |=> integ_q < $past(integ_q))
    else $error("integrator did not leak while link lost");

  a_lvl_range: assert property ( // RULE_18
    lvl_q >= `CVSD_LVL_MIN)
    else $error("level below minimum step");

  a_out_history: assert property ( // RULE_02
    ser_out == hist_q[0])
    else $error("output bit differs from newest history bit");

  a_enc_hist: assert property ( // RULE_15
    fall && enc_s_q |=> hist_q[0] == $past(ana_h_q > integ_q))
    else $error("encode history did not take comparator");

  a_dec_hist: assert property ( // RULE_15
    fall && !enc_s_q |=> hist_q[0] == !$past(dat_s_q))
    else $error("decode history did not take data input");

  a_ana_settled: assert property ( // RULE_01
    !ana_same |=> $stable(ana_h_q))
    else $error("moving input word reached the comparator");

  a_one_bit: assert property ( // RULE_11
    fall |=> !fall)
    else $error("more than one bit taken per clock");

  a_hold_idle: assert property ( // RULE_03
    !fall && !tick |=> $stable(integ_out) && $stable(lvl_q))
    else $error("integrator or level moved between bits");

  a_integ_sym: assert property ( // RULE_07
    integ_out != 16'sh8000)
    else $error("integrator left its symmetric range");

  a_lvl_floor: assert property ( // RULE_08
    fall && !coinc_now && lvl_q == `CVSD_LVL_MIN |=> lvl_q == `CVSD_LVL_MIN)
    else $error("idle step fell below minimum");

  // Loss timer: restarts on every bit, flags loss only without bits
  a_cnt_clear: assert property ( // RULE_12
    fall |=> cnt_q == 12'h000)
    else $error("loss timer not restarted by a bit");

  a_loss_timeout: assert property ( // RULE_12
    !fall && cnt_q == 12'(`CVSD_LOSS_CYC - 1) |=> link_lost)
    else $error("link loss not flagged at timeout");

  a_link_clear: assert property ( // RULE_12
    fall |=> !link_lost)
    else $error("link loss not cleared by a bit");

  a_link_keep: assert property ( // RULE_12
    link_lost && !fall |=> link_lost)
    else $error("link loss cleared without a bit");

  a_lost_quiet: assert property ( // RULE_12
    link_lost |-> $stable(ser_out))
    else $error("output bit moved while link lost");

  a_tick_level: assert property ( // RULE_12
    tick && lvl_q > `CVSD_LVL_MIN |=> lvl_q < $past(lvl_q))
    else $error("level did not decay while link lost");

  // Buffer checks: the consumer may stall for any number of cycles
  a_smp_push: assert property ( // RULE_11
    fall && !smp_valid |=>
      smp_valid && smp_data.chan_bit == ser_out &&
      smp_data.integ == integ_out)
    else $error("channel bit not buffered into empty queue");

  a_smp_hold: assert property ( // RULE_11
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("queue head changed while stalled");

  a_smp_pop: assert property ( // RULE_11
    smp_valid && smp_ready && !fall |=> smp_space)
    else $error("no space after a pop without push");

  a_smp_full: assert property ( // RULE_11
    !smp_space && !(smp_valid && smp_ready) |=> !smp_space)
    else $error("full queue gained space without a pop");

endmodule

// ---- cvsd_far_end.sv ----
`timescale 1ns/1ps

module cvsd_far_end
(
  input  wire logic ref_clk,
  output logic      bit_clk,
  output logic      data_out
);
  initial
  begin
    bit_clk  = 1'b1;
    data_out = 1'b0;
  end

  // Falls 401 cycles apart, about 62.3 kHz; clock stands high between bits
  task automatic send_bit(input logic b);
    @(posedge ref_clk) #1;
    data_out = ~b;
    repeat (13) @(posedge ref_clk);
    #1 bit_clk = 1'b0;
    repeat (13) @(posedge ref_clk);
    // Hold time over: line no longer carries the bit
    #1 data_out = b;
    repeat (187) @(posedge ref_clk);
    #1 bit_clk = 1'b1;
    repeat (187) @(posedge ref_clk);
    // Return off the edge so the caller never races the clock
    #1;
  endtask
endmodule

// ---- test_cvsd_slope_control_core.sv ----
`timescale 1ns/1ps

module test_cvsd_slope_control_core;
  import cvsd_pkg::*;
  logic               ref_clk;
  logic               rst_n;
  logic               enc_mode;
  logic               smp_ready;
  logic               bit_clk;
  logic               data_in;
  logic signed [15:0] analog_in;
  logic signed [15:0] integ_out;
  logic signed [15:0] prev;
  logic               ser_out;
  logic               last;
  logic               coinc_n;
  logic               link_lost;
  logic               smp_valid;
  logic               smp_space;
  cvsd_smp_t          smp_data;
  int                 n_mismatch;
  int                 cmp_count;
  int                 cyc;
  int                 n;

  cvsd_core i_cvsd_core
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .bit_clk   (bit_clk),
    .enc_mode  (enc_mode),
    .data_in   (data_in),
    .analog_in (analog_in),
    .ser_out   (ser_out),
    .coinc_n   (coinc_n),
    .integ_out (integ_out),
    .link_lost (link_lost),
    .smp_valid (smp_valid),
    .smp_ready (smp_ready),
    .smp_data  (smp_data),
    .smp_space (smp_space)
  );

  cvsd_far_end i_cvsd_far_end
  (
    .ref_clk  (ref_clk),
    .bit_clk  (bit_clk),
    .data_out (data_in)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs about 16400 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t %s", $time, m);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk) #1;
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
  endtask

  task automatic t_reset();
    chk_bit(ser_out, 1'b0, "ser_out after reset");
    chk_bit(coinc_n, 1'b1, "coinc_n after reset");
    chk_bit(integ_out == 16'sh0000, 1'b1, "integ after reset");
    chk_bit(link_lost, 1'b1, "link_lost after reset");
    chk_bit(smp_valid, 1'b0, "fifo not empty");
    chk_bit(smp_space, 1'b1, "fifo not free");
  endtask

  // Data line says 0 while the comparator says 1: mode must pick comparator
  task automatic t_encode();
    enc_mode  = 1'b1;
    analog_in = 16'sh4000;
    for (int i = 0; i < 5; i++)
    begin
      prev = integ_out;
      i_cvsd_far_end.send_bit(1'b0);
      chk_bit(ser_out, 1'b1, "encode bit");
      chk_bit(integ_out > prev, 1'b1, "ramp up");
      if (i == 0)
        chk_bit(integ_out == 16'sh0010, 1'b1, "first step");
      if (i < 3)
        chk_bit(coinc_n, i < 2, "coincidence");
    end
    chk_bit(integ_out - prev > 16'sh0020, 1'b1, "step grew");
  endtask

  task automatic t_loss();
    prev = integ_out;
    repeat (2700) @(posedge ref_clk);
    chk_bit(link_lost, 1'b1, "loss flag");
    chk_bit(integ_out < prev, 1'b1, "leak");
    i_cvsd_far_end.send_bit(1'b1);
    chk_bit(link_lost, 1'b0, "resume");
  endtask

  task automatic t_decode();
    enc_mode = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      prev = integ_out;
      i_cvsd_far_end.send_bit(1'b0);
      chk_bit(ser_out, 1'b0, "decode bit");
      chk_bit(integ_out < prev, 1'b1, "ramp down");
      chk_bit(coinc_n, i < 2, "decode coincidence");
    end
  endtask

  task automatic t_idle();
    do_reset();
    enc_mode  = 1'b1;
    analog_in = 16'sh0000;
    for (int i = 0; i < 8; i++)
    begin
      last = ser_out;
      i_cvsd_far_end.send_bit(1'b0);
      if (i > 0)
        chk_bit(ser_out, ~last, "idle alternation");
      chk_bit(coinc_n, 1'b1, "idle coincidence");
    end
  endtask

  // Consumer stalls while 17 bits arrive; newest is dropped
  task automatic t_fifo();
    do_reset();
    enc_mode = 1'b0;
    for (int i = 0; i < 17; i++)
      i_cvsd_far_end.send_bit(i[0] == 1'b0);
    chk_bit(smp_space, 1'b0, "fifo full");
    chk_bit(smp_data.chan_bit, 1'b1, "fifo head");
    chk_bit(smp_data.integ == 16'sh0010, 1'b1, "fifo head integ");
    @(posedge ref_clk) #1;
    smp_ready = 1'b1;
    n = 0;
    repeat (20)
    begin
      if (smp_valid === 1'b1)
      begin
        chk_bit(smp_data.chan_bit, n[0] == 1'b0, "fifo order");
        n++;
      end
      @(posedge ref_clk) #1;
    end
    chk_bit(n == 16, 1'b1, "drain count");
    chk_bit(smp_valid, 1'b0, "fifo empty");
    smp_ready = 1'b0;
  endtask

  initial
  begin
    rst_n     = 1'b0;
    enc_mode  = 1'b1;
    smp_ready = 1'b0;
    analog_in = 16'sh0000;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_encode();
    t_loss();
    t_decode();
    t_idle();
    t_fifo();
    report_and_stop();
  end
endmodule
